// ### inc/diag_cfg.svh
// Offsets, field positions, constants and timing of the output module diagnostic record
`ifndef DIAG_CFG_SVH
`define DIAG_CFG_SVH

// Record set numbers
`define REC_SHORT 8'h00
`define REC_FULL 8'h01

// Record sizes in bytes
`define REC_SHORT_LEN 5'h04
`define REC_FULL_LEN 5'h14

// Byte offsets inside the record
`define OFS_ERR_SUM_A 5'h00
`define OFS_MOD_INFO 5'h01
`define OFS_RESERVED2 5'h02
`define OFS_ERR_SUM_D 5'h03
`define OFS_CH_TYPE 5'h04
`define OFS_BITS_PER_CH 5'h05
`define OFS_CH_COUNT 5'h06
`define OFS_CH_BITMAP 5'h07
`define OFS_CH_ERR0 5'h08
`define OFS_CH_ERR7 5'h0F
`define OFS_STAMP0 5'h10
`define OFS_STAMP3 5'h13

// Subindex of the channel 7 byte and of the time stamp
`define SUB_CH_ERR7 8'h11
`define SUB_STAMP 8'h13

// First summary byte bit positions
`define BIT_A_MOD_FAIL 0
`define BIT_A_INT_ERR 1
`define BIT_A_EXT_ERR 2
`define BIT_A_CH_ERR 3
`define BIT_A_AUX_MISS 4
`define BIT_A_PARAM_ERR 7

// Second summary byte bit positions
`define BIT_D_COMM_ERR 4

// Module information fields
`define MOD_CLASS_DIGITAL 4'hF
`define BIT_MOD_CH_INFO 4

// Channel specific byte bit positions
`define BIT_CH_PARAM 0
`define BIT_CH_SHORT 2

// Fixed descriptor values
`define CH_TYPE_DIG_OUT 7'h72
`define BITS_PER_CH 8'h08
`define NUM_CHANNELS 8'h08
`define CH_ERR_RESET 8'h00
`define STAMP_RESET 32'h0000_0000

// Timing
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000
`define CYCLES_PER_US (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ### inc/diag_pkg.sv
// Types shared by the diagnostic record logic
package diag_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [4:0] rec_index_t;
    typedef logic [31:0] stamp_t;

endpackage : diag_pkg

// ### verilog/diag_sync2.sv
// Two flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module diag_sync2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Levels in and out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : diag_sync2

// ### verilog/diagnostic_timestamp_ticker.sv
// Free running 32-bit microsecond ticker
`timescale 1ns/100ps
`include "diag_cfg.svh"
module diagnostic_timestamp_ticker #(
    parameter int CYCLES_PER_US = `CYCLES_PER_US
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Ticker value
    output diag_pkg::stamp_t o_ticks
);
    import diag_pkg::*;

    localparam int PW = (CYCLES_PER_US > 1) ? $clog2(CYCLES_PER_US) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_US - 1);

    logic [PW-1:0] pre_r;
    stamp_t ticks_r;

    // Divide the clock down to one step per microsecond
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_r <= '0;
        end else if (pre_r == PRE_LAST) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PW'(1);
        end
    end

    // Count from zero at power on, wrap after the top value
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ticks_r <= `STAMP_RESET;
        end else if (pre_r == PRE_LAST) begin
            ticks_r <= ticks_r + 32'h0000_0001;
        end
    end

    assign o_ticks = ticks_r;

endmodule : diagnostic_timestamp_ticker

// ### verilog/diag_record.sv
// Read-only diagnostic record of an eight channel digital output module
`timescale 1ns/100ps
`include "diag_cfg.svh"
module diag_record #(
    parameter int CHANNELS = 8,
    parameter int CYCLES_PER_US = `CYCLES_PER_US
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Module level fault inputs, asynchronous levels
    input wire logic i_module_fail,
    input wire logic i_internal_err,
    input wire logic i_external_err,
    input wire logic i_aux_missing,
    input wire logic i_param_err,
    input wire logic i_comm_err,
    // Channel fault inputs, asynchronous levels
    input wire logic [CHANNELS-1:0] i_ch_param_err,
    input wire logic [CHANNELS-1:0] i_ch_short,
    // Record read port, same clock domain
    input wire logic i_rd_req,
    input wire diag_pkg::byte_t i_record_set_number,
    input wire diag_pkg::rec_index_t i_rd_index,
    output logic o_rd_valid,
    output logic o_rd_error,
    output diag_pkg::byte_t o_rd_data,
    // Event and time outputs
    output logic o_diag_event,
    output diag_pkg::stamp_t o_ticks
);
    import diag_pkg::*;

    localparam int NSRC = 6 + 2 * CHANNELS;

    // Synchronised fault levels
    logic [NSRC-1:0] raw_src;
    logic [NSRC-1:0] src_sync;
    logic [NSRC-1:0] src_prev_r;
    logic mod_fail;
    logic int_err;
    logic ext_err_pin;
    logic aux_miss;
    logic param_err;
    logic comm_err;
    logic [CHANNELS-1:0] ch_param;
    logic [CHANNELS-1:0] ch_short;

    // Record contents
    byte_t err_sum_a_r;
    byte_t err_sum_d_r;
    byte_t ch_bitmap_r;
    byte_t ch_err_r [CHANNELS];
    stamp_t stamp_r;
    stamp_t ticks;
    logic event_r;

    // Read port state
    logic rd_valid_r;
    logic rd_error_r;
    byte_t rd_data_r;

    // Limit for one record set
    function automatic logic index_ok(input byte_t set, input rec_index_t idx);
        logic ok;
        ok = 1'b0;
        if (set == `REC_SHORT) begin
            ok = (idx < `REC_SHORT_LEN);
        end else if (set == `REC_FULL) begin
            ok = (idx < `REC_FULL_LEN);
        end
        return ok;
    endfunction : index_ok

    // Bring all fault levels into the clock domain
    assign raw_src = {i_ch_short, i_ch_param_err, i_comm_err, i_param_err,
                      i_aux_missing, i_external_err, i_internal_err, i_module_fail};

    diag_sync2 #(
        .W(NSRC)
    ) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(raw_src),
        .o_sync(src_sync)
    );

    // Split the synchronised vector
    assign mod_fail = src_sync[0];
    assign int_err = src_sync[1];
    assign ext_err_pin = src_sync[2];
    assign aux_miss = src_sync[3];
    assign param_err = src_sync[4];
    assign comm_err = src_sync[5];
    assign ch_param = src_sync[6 +: CHANNELS];
    assign ch_short = src_sync[6 + CHANNELS +: CHANNELS];

    // Microsecond time base
    diagnostic_timestamp_ticker #(
        .CYCLES_PER_US(CYCLES_PER_US)
    ) u_ticker (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .o_ticks(ticks)
    );

    // Channel specific bytes, reserved bits held at zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                ch_err_r[i] <= `CH_ERR_RESET;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                ch_err_r[i] <= '0;
                ch_err_r[i][`BIT_CH_PARAM] <= ch_param[i];
                ch_err_r[i][`BIT_CH_SHORT] <= ch_short[i];
            end
        end
    end

    // Bitmap mirrors any fault of each channel
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ch_bitmap_r <= 8'h00;
        end else begin
            ch_bitmap_r <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                ch_bitmap_r[i] <= ch_param[i] | ch_short[i];
            end
        end
    end

    // First summary byte
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_sum_a_r <= 8'h00;
        end else begin
            err_sum_a_r <= '0;
            err_sum_a_r[`BIT_A_MOD_FAIL] <= mod_fail;
            err_sum_a_r[`BIT_A_INT_ERR] <= int_err | comm_err;
            err_sum_a_r[`BIT_A_EXT_ERR] <= ext_err_pin | (|ch_short);
            err_sum_a_r[`BIT_A_CH_ERR] <= |(ch_param | ch_short);
            err_sum_a_r[`BIT_A_AUX_MISS] <= aux_miss;
            err_sum_a_r[`BIT_A_PARAM_ERR] <= param_err | (|ch_param);
        end
    end

    // Second summary byte
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_sum_d_r <= 8'h00;
        end else begin
            err_sum_d_r <= '0;
            err_sum_d_r[`BIT_D_COMM_ERR] <= comm_err;
        end
    end

    // A new fault on any source is a diagnostic event
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_prev_r <= '0;
            event_r <= 1'b0;
        end else begin
            src_prev_r <= src_sync;
            event_r <= |(src_sync & ~src_prev_r);
        end
    end

    // Capture the ticker at the event
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stamp_r <= `STAMP_RESET;
        end else if (|(src_sync & ~src_prev_r)) begin
            stamp_r <= ticks;
        end
    end

    // Record read answer one cycle after the request
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_valid_r <= 1'b0;
            rd_error_r <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            rd_valid_r <= i_rd_req;
            rd_error_r <= i_rd_req & ~index_ok(i_record_set_number, i_rd_index);
            if (i_rd_req) begin
                rd_data_r <= 8'h00;
                if (index_ok(i_record_set_number, i_rd_index)) begin
                    case (i_rd_index)
                        `OFS_ERR_SUM_A: begin
                            rd_data_r <= err_sum_a_r;
                        end
                        `OFS_MOD_INFO: begin
                            rd_data_r <= {3'h0, 1'b1, `MOD_CLASS_DIGITAL};
                        end
                        `OFS_ERR_SUM_D: begin
                            rd_data_r <= err_sum_d_r;
                        end
                        `OFS_CH_TYPE: begin
                            rd_data_r <= {1'b0, `CH_TYPE_DIG_OUT};
                        end
                        `OFS_BITS_PER_CH: begin
                            rd_data_r <= `BITS_PER_CH;
                        end
                        `OFS_CH_COUNT: begin
                            rd_data_r <= `NUM_CHANNELS;
                        end
                        `OFS_CH_BITMAP: begin
                            rd_data_r <= ch_bitmap_r;
                        end
                        default: begin
                            if (i_rd_index >= `OFS_STAMP0) begin
                                rd_data_r <= stamp_r[8 * (i_rd_index - `OFS_STAMP0) +: 8];
                            end else if (i_rd_index >= `OFS_CH_ERR0 && i_rd_index <= `OFS_CH_ERR7) begin
                                rd_data_r <= ch_err_r[3'(i_rd_index - `OFS_CH_ERR0)];
                            end
                        end
                    endcase
                end
            end
        end
    end

    assign o_rd_valid = rd_valid_r;
    assign o_rd_error = rd_error_r;
    assign o_rd_data = rd_data_r;
    assign o_diag_event = event_r;
    assign o_ticks = ticks;

endmodule : diag_record

// ### verif/diag_record_props.sv
// Checker for the diagnostic record read port and ticker
`timescale 1ns/100ps
module diag_record_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Read port
    input wire logic i_rd_req,
    input wire diag_pkg::byte_t i_record_set_number,
    input wire diag_pkg::rec_index_t i_rd_index,
    input wire logic o_rd_valid,
    input wire logic o_rd_error,
    input wire diag_pkg::byte_t o_rd_data,
    // Event and time
    input wire logic o_diag_event,
    input wire diag_pkg::stamp_t o_ticks
);
    import diag_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic full;
    // Request for the full record
    assign full = i_rd_req && i_record_set_number == 8'h01;
    property p_answer; i_rd_req |=> o_rd_valid; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet; !i_rd_req |=> !o_rd_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_refuse; i_rd_req && i_record_set_number > 8'h01 |=> o_rd_error && o_rd_data == 8'h00; endproperty
    a_refuse: assert property (p_refuse) else $error("bad set accepted");
    property p_short; i_rd_req && i_record_set_number == 8'h00 |=> o_rd_error == $past(i_rd_index > 5'h03); endproperty
    a_short: assert property (p_short) else $error("short record length wrong");
    property p_range; full && i_rd_index > 5'h13 |=> o_rd_error; endproperty
    a_range: assert property (p_range) else $error("index past record end accepted");
    property p_modinfo; full && i_rd_index == 5'h01 |=> o_rd_data == 8'h1F && !o_rd_error; endproperty
    a_modinfo: assert property (p_modinfo) else $error("module information wrong");
    property p_chtype; full && i_rd_index == 5'h04 |=> o_rd_data == 8'h72; endproperty
    a_chtype: assert property (p_chtype) else $error("channel type wrong");
    property p_counts; full && (i_rd_index == 5'h05 || i_rd_index == 5'h06) |=> o_rd_data == 8'h08; endproperty
    a_counts: assert property (p_counts) else $error("descriptor count wrong");
    property p_resv; full && i_rd_index == 5'h02 |=> o_rd_data == 8'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved byte not zero");
    property p_tick; o_ticks == $past(o_ticks) || o_ticks == $past(o_ticks) + 32'h1; endproperty
    a_tick: assert property (p_tick) else $error("ticker jumped");
    property p_moves; o_ticks == $past(o_ticks) |-> ##[1:100] o_ticks != $past(o_ticks); endproperty
    a_moves: assert property (p_moves) else $error("ticker stalled");
    c_read: cover property (full ##1 o_rd_valid);
    c_err: cover property (o_rd_error);
    c_event: cover property (o_diag_event);
endmodule : diag_record_props

bind diag_record diag_record_props i_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_rd_req(i_rd_req),
    .i_record_set_number(i_record_set_number), .i_rd_index(i_rd_index), .o_rd_valid(o_rd_valid),
    .o_rd_error(o_rd_error), .o_rd_data(o_rd_data), .o_diag_event(o_diag_event), .o_ticks(o_ticks));

// ### verif/record_reader.sv
// Bus coupler model issuing record reads
`timescale 1ns/100ps
module record_reader (
    // Clock
    input wire logic i_clk,
    // Read request toward the record
    output logic o_req,
    output diag_pkg::byte_t o_set,
    output diag_pkg::rec_index_t o_idx
);
    import diag_pkg::*;
    // Idle at time zero
    initial begin
        o_req = 1'b0;
        o_set = 8'hA5;
        o_idx = 5'h0A;
    end
    // One request held for a full cycle, back to back allowed
    task automatic rd(input byte_t s, input rec_index_t i);
        o_req = 1'b1;
        o_set = s;
        o_idx = i;
        @(negedge i_clk);
    endtask : rd
    // Release; set and index turn to junk
    task automatic idle();
        o_req = 1'b0;
        o_set = ~o_set;
        o_idx = ~o_idx;
        @(negedge i_clk);
    endtask : idle
endmodule : record_reader

// ### verif/diag_record_tb_top.sv
// Self-checking bench for the diagnostic record
`timescale 1ns/100ps
module diag_record_tb_top;
    import diag_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [5:0] flt = 6'h00;
    logic [7:0] chp = 8'h00;
    logic [7:0] sh = 8'h00;
    logic rq, o_rd_valid, o_rd_error, o_diag_event;
    byte_t rs, o_rd_data;
    rec_index_t ri;
    stamp_t o_ticks;
    int error_cnt = 0;
    int comparisons = 0;
    int e = 0;
    int ea;
    logic [17:0] q[$];
    logic [17:0] n;
    logic [8:0] a, d;
    logic [8:0] got;
    logic [21:0] old;
    stamp_t exp_t;
    byte_t rst_tab[20] = '{1: 8'h1F, 4: 8'h72, 5: 8'h08, 6: 8'h08, default: 8'h00};
    always #10 i_clk = ~i_clk;
    // Edges since reset release
    always @(posedge i_clk) e <= i_rstn ? e + 1 : 0;
    diag_record #(.CHANNELS(8), .CYCLES_PER_US(2)) i_diag_record (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_module_fail(flt[0]), .i_internal_err(flt[1]), .i_external_err(flt[2]), .i_aux_missing(flt[3]),
        .i_param_err(flt[4]), .i_comm_err(flt[5]), .i_ch_param_err(chp), .i_ch_short(sh),
        .i_rd_req(rq), .i_record_set_number(rs), .i_rd_index(ri), .o_rd_valid(o_rd_valid),
        .o_rd_error(o_rd_error), .o_rd_data(o_rd_data), .o_diag_event(o_diag_event), .o_ticks(o_ticks));
    record_reader i_rdr (.i_clk(i_clk), .o_req(rq), .o_set(rs), .o_idx(ri));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // Note the expected answer range, then request
    task automatic rd(input byte_t s, input rec_index_t i, input logic [8:0] lo, input logic [8:0] hi);
        q.push_back({lo, hi});
        i_rdr.rd(s, i);
    endtask : rd
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // Oldest note against each answer
    always @(negedge i_clk) begin
        if (o_rd_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk("answer without note", 32'h1, 32'h0);
            end else begin
                n = q.pop_front();
                got = {o_rd_error, o_rd_data};
                chk("read", got, ((got >= n[17:9]) && (got <= n[8:0])) === 1'b1 ? got : n[17:9]);
            end
        end
    end
    // Cut a hang short
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    // Test sequence
    initial begin
        void'($urandom(11));
        repeat (16) @(negedge i_clk);
        i_rstn = 1'b1;
        for (int k = 0; k < 20; k++) rd(8'h01, k[4:0], {1'b0, rst_tab[k]}, {1'b0, rst_tab[k]});
        for (int k = 0; k < 6; k++) begin
            d = (k < 4) ? {1'b0, rst_tab[k]} : 9'h100;
            rd(8'h00, k[4:0], d, d);
        end
        rd(8'h02, 5'h00, 9'h100, 9'h100);
        rd(8'h01, 5'h14, 9'h100, 9'h100);
        i_rdr.idle();
        $display("layout test done");
        // Ticker steps once per two edges in this build
        repeat (3) begin
            @(negedge i_clk);
            exp_t = ((o_ticks + 1 >= e / 2) && (o_ticks <= e / 2 + 1)) === 1'b1 ? o_ticks : e / 2;
            chk("ticks", o_ticks, exp_t);
        end
        $display("ticker test done");
        for (int r = 0; r < 4; r++) begin
            old = {flt, chp, sh};
            flt = 6'($urandom);
            chp = 8'($urandom);
            sh = 8'($urandom) | 8'(r == 0);
            ea = e;
            // Event pulse stands one cycle, three edges after a rising fault
            repeat (3) @(negedge i_clk);
            chk("event", {31'h0, o_diag_event}, {31'h0, |({flt, chp, sh} & ~old)});
            @(negedge i_clk);
            chk("event end", {31'h0, o_diag_event}, 32'h0);
            @(negedge i_clk);
            a = {flt[4] | |chp, 2'b00, flt[3], |(chp | sh), flt[2] | |sh, flt[1] | flt[5], flt[0]};
            rd(8'h01, 5'h00, a, a);
            rd(8'h01, 5'h03, {4'h0, flt[5], 4'h0}, {4'h0, flt[5], 4'h0});
            rd(8'h01, 5'h07, {1'b0, chp | sh}, {1'b0, chp | sh});
            for (int c = 0; c < 8; c++) begin
                d = {6'h00, sh[c], 1'b0, chp[c]};
                rd(8'h01, 5'h08 + c[4:0], d, d);
            end
            if (r == 0) begin
                rd(8'h01, 5'h10, 9'(ea / 2 - 1), 9'(ea / 2 + 3));
                for (int k = 17; k < 20; k++) rd(8'h01, k[4:0], 9'h000, 9'h000);
            end
            i_rdr.idle();
            $display("fault round %0d done", r);
        end
        repeat (2) @(negedge i_clk);
        chk("notes left", q.size(), 32'h0);
        results();
    end
endmodule : diag_record_tb_top
